// ### src/ftoec_pkg.sv
// Package: register map, field layout and timing constants for the offset/event config block
package ftoec_pkg;
	// -----------------------------------------------------------------
	// Register indices (byte address = 4 x index)
	// -----------------------------------------------------------------
	localparam logic [7:0] IDX_UP_OFFSETS = 8'h3d;
	localparam logic [7:0] IDX_DN_OFFSETS = 8'h3e;
	localparam logic [7:0] IDX_EVT_RATES = 8'h3f;
	localparam logic [7:0] IDX_EVT_COUNTS = 8'h40;
	localparam logic [7:0] IDX_CTRL = 8'h50;
	localparam logic [7:0] IDX_STATUS = 8'h51;
	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] RST_UP_OFFSETS = 16'h0000;
	localparam logic [15:0] RST_DN_OFFSETS = 16'h0000;
	localparam logic [15:0] RST_EVT_RATES = 16'h0000;
	localparam logic [15:0] RST_EVT_COUNTS = 16'h0000;
	localparam logic [15:0] RST_CTRL = 16'h0000;
	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int RET_LSB = 8;
	localparam int FRONT_LSB = 0;
	localparam int DIFF_RATE_LSB = 12;
	localparam int DIFF_CNT_LSB = 7;
	localparam int TEMP_RATE_LSB = 1;
	localparam int MULT_BIT = 0;
	localparam int TEMP_CNT_LSB = 11;
	localparam int CTRL_POL_BIT = 0;
	localparam int CTRL_SEQ1_BIT = 1;
	localparam int CTRL_SEQ3_BIT = 2;
	localparam int CTRL_HALT_BIT = 3;
	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int DIFF_STEP_MS = 500;
	localparam int TEMP_STEP_MS = 1000;
	localparam int DIFF_STEP_CYC = DIFF_STEP_MS * (CLK_HZ / 1000);
	localparam int TEMP_STEP_CYC = TEMP_STEP_MS * (CLK_HZ / 1000);
	localparam int MULT_SHIFT = 3;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FIRE} ftoec_seq_e;
endpackage

// ### src/ftoec_seq_if.sv
// Interface: settings and events between register bank and interval sequencer
`timescale 1ns/10ps
`default_nettype none
interface ftoec_seq_if;
	logic start;
	logic halt;
	logic temp_mode;
	logic [5:0] rate;
	logic [4:0] count;
	logic mult;
	logic fire;
	logic busy;
	modport bank (output start, halt, temp_mode, rate, count, mult, input fire, busy);
	modport seq (input start, halt, temp_mode, rate, count, mult, output fire, busy);
endinterface
`default_nettype wire

// ### src/ftoec_seq.sv
// Interval sequencer: runs count+1 measurement slots spaced by a scaled interval
`timescale 1ns/10ps
`default_nettype none
module ftoec_seq #(
	parameter int DIFF_STEP = ftoec_pkg::DIFF_STEP_CYC,
	parameter int TEMP_STEP = ftoec_pkg::TEMP_STEP_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	ftoec_seq_if.seq sif
);
	ftoec_pkg::ftoec_seq_e state_reg;
	logic [31:0] timer_reg;
	logic [5:0] left_reg;
	logic [31:0] interval;
	logic [31:0] step;

	// Interval = step x (1 + rate), divided by eight in fast mode
	always_comb begin
		step = sif.temp_mode ? 32'(TEMP_STEP) : 32'(DIFF_STEP);
		interval = step * (32'(sif.rate) + 32'h1);
		if (sif.mult) begin
			interval = interval >> ftoec_pkg::MULT_SHIFT;
		end
		if (interval == 32'h0) begin
			interval = 32'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg <= ftoec_pkg::ST_IDLE;
			timer_reg <= 32'h0;
			left_reg <= 6'h0;
		end else if (sif.halt) begin
			state_reg <= ftoec_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				ftoec_pkg::ST_IDLE: begin
					if (sif.start) begin
						// Count field plus one slots
						left_reg <= {1'b0, sif.count} + 6'h1;
						state_reg <= ftoec_pkg::ST_FIRE;
					end
				end
				ftoec_pkg::ST_FIRE: begin
					left_reg <= left_reg - 6'h1;
					timer_reg <= interval - 32'h1;
					state_reg <= (left_reg == 6'h1) ? ftoec_pkg::ST_IDLE : ftoec_pkg::ST_WAIT;
				end
				ftoec_pkg::ST_WAIT: begin
					if (timer_reg <= 32'h1) begin
						state_reg <= ftoec_pkg::ST_FIRE;
					end else begin
						timer_reg <= timer_reg - 32'h1;
					end
				end
				default: begin
					state_reg <= ftoec_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign sif.fire = (state_reg == ftoec_pkg::ST_FIRE) && !sif.halt;
	assign sif.busy = (state_reg != ftoec_pkg::ST_IDLE);

	AST_SLOTS_ONE_MORE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(state_reg == ftoec_pkg::ST_IDLE && sif.start && !sif.halt)
		|=> (left_reg == {1'b0, $past(sif.count)} + 6'h1))
		else $error("slot count is not count plus one");
	AST_FIRE_SPACING: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(sif.fire && left_reg != 6'h1) |=> !sif.fire [*1])
		else $error("back to back slots");
endmodule
`default_nettype wire

// ### src/ftoec_top.sv
// Top: offset and event-timing register bank with Avalon-MM slave and sequencer
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ftoec_top #(
	parameter int DIFF_STEP = ftoec_pkg::DIFF_STEP_CYC,
	parameter int TEMP_STEP = ftoec_pkg::TEMP_STEP_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_up_active,
	input wire logic i_early_edge,
	output logic signed [8:0] o_comparator_offset,
	output logic o_differential_flight_time_cmd,
	output logic o_temp_cycle_cmd,
	output logic o_seq_busy
);
	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic [15:0] up_offsets_reg;
	logic [15:0] dn_offsets_reg;
	logic [15:0] evt_rates_reg;
	logic [15:0] evt_counts_reg;
	logic [15:0] ctrl_reg;
	logic returned_reg;
	logic ack_reg;
	logic temp_mode_reg;
	logic [7:0] idx;
	logic wr_lo;
	logic wr_hi;
	logic wr_go;
	ftoec_seq_if sif();

	assign idx = i_avs_address[9:2];
	// Write lands on the edge that sees waitrequest low, never during the wait state
	assign wr_go = i_avs_write && ack_reg;
	assign wr_lo = wr_go && i_avs_byteenable[0];
	assign wr_hi = wr_go && i_avs_byteenable[1];
	// One wait state on every access
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
		end
	end

	// Byte-lane writes; bit 7 of offset registers is reserved
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			up_offsets_reg <= ftoec_pkg::RST_UP_OFFSETS;
			dn_offsets_reg <= ftoec_pkg::RST_DN_OFFSETS;
			evt_rates_reg <= ftoec_pkg::RST_EVT_RATES;
			evt_counts_reg <= ftoec_pkg::RST_EVT_COUNTS;
			ctrl_reg <= ftoec_pkg::RST_CTRL;
		end else begin
			ctrl_reg[ftoec_pkg::CTRL_SEQ3_BIT:ftoec_pkg::CTRL_SEQ1_BIT] <= 2'h0;
			ctrl_reg[ftoec_pkg::CTRL_HALT_BIT] <= 1'b0;
			case (idx)
				ftoec_pkg::IDX_UP_OFFSETS: begin
					if (wr_lo) up_offsets_reg[7:0] <= {1'b0, i_avs_writedata[6:0]};
					if (wr_hi) up_offsets_reg[15:8] <= i_avs_writedata[15:8];
				end
				ftoec_pkg::IDX_DN_OFFSETS: begin
					if (wr_lo) dn_offsets_reg[7:0] <= {1'b0, i_avs_writedata[6:0]};
					if (wr_hi) dn_offsets_reg[15:8] <= i_avs_writedata[15:8];
				end
				ftoec_pkg::IDX_EVT_RATES: begin
					if (wr_lo) evt_rates_reg[7:0] <= i_avs_writedata[7:0];
					if (wr_hi) evt_rates_reg[15:8] <= i_avs_writedata[15:8];
				end
				ftoec_pkg::IDX_EVT_COUNTS: begin
					if (wr_lo) evt_counts_reg[7:0] <= i_avs_writedata[7:0];
					if (wr_hi) evt_counts_reg[15:8] <= i_avs_writedata[15:8];
				end
				ftoec_pkg::IDX_CTRL: begin
					if (wr_lo) ctrl_reg[3:0] <= i_avs_writedata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Readback; unmapped indices read zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_avs_readdata <= 32'h0;
		end else if (i_avs_read && !ack_reg) begin
			case (idx)
				ftoec_pkg::IDX_UP_OFFSETS: o_avs_readdata <= {16'h0, up_offsets_reg};
				ftoec_pkg::IDX_DN_OFFSETS: o_avs_readdata <= {16'h0, dn_offsets_reg};
				ftoec_pkg::IDX_EVT_RATES: o_avs_readdata <= {16'h0, evt_rates_reg};
				ftoec_pkg::IDX_EVT_COUNTS: o_avs_readdata <= {16'h0, evt_counts_reg};
				ftoec_pkg::IDX_CTRL: o_avs_readdata <= {31'h0, ctrl_reg[ftoec_pkg::CTRL_POL_BIT]};
				ftoec_pkg::IDX_STATUS: o_avs_readdata <= {30'h0, returned_reg, sif.busy};
				default: o_avs_readdata <= 32'h0;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Comparator offset selection
	// -----------------------------------------------------------------
	// Cleared only once the sequencer is idle with no command out, so each sequence starts on front offset
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			returned_reg <= 1'b0;
		end else if (i_early_edge) begin
			returned_reg <= 1'b1;
		end else if (!o_differential_flight_time_cmd && !o_temp_cycle_cmd && !sif.busy) begin
			returned_reg <= 1'b0;
		end
	end

	logic [7:0] ret_byte;
	logic [6:0] front_mag;
	always_comb begin
		ret_byte = i_up_active ? up_offsets_reg[15:ftoec_pkg::RET_LSB]
			: dn_offsets_reg[15:ftoec_pkg::RET_LSB];
		front_mag = i_up_active ? up_offsets_reg[6:ftoec_pkg::FRONT_LSB]
			: dn_offsets_reg[6:ftoec_pkg::FRONT_LSB];
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_comparator_offset <= 9'sh000;
		end else if (returned_reg || i_early_edge) begin
			o_comparator_offset <= 9'($signed({ret_byte[7], ret_byte}));
		end else if (ctrl_reg[ftoec_pkg::CTRL_POL_BIT]) begin
			o_comparator_offset <= -$signed({2'b00, front_mag});
		end else begin
			o_comparator_offset <= $signed({2'b00, front_mag});
		end
	end

	// -----------------------------------------------------------------
	// Event sequencing
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			temp_mode_reg <= 1'b0;
		end else if (ctrl_reg[ftoec_pkg::CTRL_SEQ3_BIT] && !sif.busy) begin
			temp_mode_reg <= 1'b1;
		end else if (ctrl_reg[ftoec_pkg::CTRL_SEQ1_BIT] && !sif.busy) begin
			temp_mode_reg <= 1'b0;
		end
	end

	assign sif.start = (ctrl_reg[ftoec_pkg::CTRL_SEQ1_BIT] || ctrl_reg[ftoec_pkg::CTRL_SEQ3_BIT])
		&& !sif.busy;
	assign sif.halt = ctrl_reg[ftoec_pkg::CTRL_HALT_BIT];
	assign sif.temp_mode = ctrl_reg[ftoec_pkg::CTRL_SEQ3_BIT] ? 1'b1
		: (ctrl_reg[ftoec_pkg::CTRL_SEQ1_BIT] ? 1'b0 : temp_mode_reg);
	assign sif.rate = sif.temp_mode ? evt_rates_reg[6:ftoec_pkg::TEMP_RATE_LSB]
		: {2'b00, evt_rates_reg[15:ftoec_pkg::DIFF_RATE_LSB]};
	assign sif.count = sif.temp_mode ? evt_counts_reg[15:ftoec_pkg::TEMP_CNT_LSB]
		: evt_rates_reg[11:ftoec_pkg::DIFF_CNT_LSB];
	assign sif.mult = evt_rates_reg[ftoec_pkg::MULT_BIT];

	ftoec_seq #(
		.DIFF_STEP(DIFF_STEP),
		.TEMP_STEP(TEMP_STEP)
	) u_seq (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.sif(sif)
	);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_differential_flight_time_cmd <= 1'b0;
			o_temp_cycle_cmd <= 1'b0;
			o_seq_busy <= 1'b0;
		end else begin
			o_differential_flight_time_cmd <= sif.fire && !temp_mode_reg;
			o_temp_cycle_cmd <= sif.fire && temp_mode_reg;
			o_seq_busy <= sif.busy;
		end
	end

	AST_RETURN_AFTER_EDGE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_early_edge |=> o_comparator_offset == $signed({$past(ret_byte[7]), $past(ret_byte)}))
		else $error("return offset not applied after early edge");
	AST_FRONT_SIGN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(!returned_reg && !i_early_edge && ctrl_reg[ftoec_pkg::CTRL_POL_BIT] && front_mag != 7'h0)
		|=> o_comparator_offset < 0)
		else $error("falling edge front offset not negative");
	AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!up_offsets_reg[7] && !dn_offsets_reg[7])
		else $error("reserved offset bit set");
	AST_RET_RANGE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(returned_reg && ret_byte == 8'h80) |=> o_comparator_offset == -9'sd128)
		else $error("return offset decode wrong");
	AST_WAIT_ONE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_avs_read && !ack_reg) |=> !o_avs_waitrequest || !i_avs_read)
		else $error("read not answered in one wait state");
endmodule
`default_nettype wire

// ### testbench/ftoec_host_model.sv
// Host model: Avalon-MM master issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module ftoec_host_model (
	input wire logic i_clk,
	output logic [9:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata,
	output logic [3:0] o_byteenable,
	input wire logic [31:0] i_readdata,
	input wire logic i_waitrequest
);
	initial begin
		o_address = 10'h000;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h00000000;
		o_byteenable = 4'h0;
	end
	// -----------------------------------------------------------------
	// Bus access
	// -----------------------------------------------------------------
	// Request held until the edge that samples waitrequest low
	task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		logic done;
		done = 1'b0;
		q = 32'h00000000;
		@(posedge i_clk);
		o_address <= a;
		o_writedata <= d;
		o_read <= !wr;
		o_write <= wr;
		o_byteenable <= 4'hf;
		for (n = 0; n < 20 && !done; n++) begin
			@(posedge i_clk);
			if (i_waitrequest === 1'b0) begin
				q = i_readdata;
				done = 1'b1;
			end
		end
		o_read <= 1'b0;
		o_write <= 1'b0;
		// Released lines show no stale value
		o_address <= ~a;
		o_writedata <= ~d;
		if (!done) begin
			ftoec_top_tb_top.compare(32'h1, 32'h0);
			ftoec_top_tb_top.tally_and_finish();
		end
	endtask
endmodule
`default_nettype wire

// ### testbench/ftoec_top_tb_top.sv
// Testbench: registers, comparator offsets and event sequences
`timescale 1ns/10ps
`default_nettype none
module ftoec_top_tb_top;
	localparam int DSTEP = 40;
	localparam int TSTEP = 80;
	logic clk = 1'b0;
	logic rst;
	logic [9:0] addr;
	logic rd_s;
	logic wr_s;
	logic [31:0] wdata;
	logic [3:0] be;
	logic [31:0] rdata;
	logic wait_s;
	logic up;
	logic edge_s;
	logic signed [8:0] offs;
	logic diff_cmd;
	logic temp_cmd;
	logic busy;
	logic pol;
	logic [15:0] ur;
	logic [15:0] dr;
	int fails = 0;
	int checked = 0;
	always #50 clk = ~clk;
	ftoec_top #(.DIFF_STEP(DSTEP), .TEMP_STEP(TSTEP)) i_ftoec_top (.i_clk(clk),
		.i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
		.i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_s), .i_up_active(up), .i_early_edge(edge_s),
		.o_comparator_offset(offs), .o_differential_flight_time_cmd(diff_cmd),
		.o_temp_cycle_cmd(temp_cmd), .o_seq_busy(busy));
	ftoec_host_model i_ftoec_host_model (.i_clk(clk), .o_address(addr), .o_read(rd_s),
		.o_write(wr_s), .o_writedata(wdata), .o_byteenable(be), .i_readdata(rdata),
		.i_waitrequest(wait_s));
	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] x;
		i_ftoec_host_model.access(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] x;
		i_ftoec_host_model.access(1'b0, a, 32'h0, x);
		compare(x, e);
	endtask
	function automatic logic [31:0] exp_off(input logic u, input logic ret);
		logic [15:0] r;
		logic signed [8:0] f;
		r = u ? ur : dr;
		f = $signed({2'b00, r[6:0]});
		if (ret) begin
			return {{24{r[15]}}, r[15:8]};
		end
		return pol ? 32'(-f) : 32'(f);
	endfunction
	task automatic wait_cmd(input int lim);
		int c;
		for (c = 0; c < lim && diff_cmd !== 1'b1; c++) begin
			@(negedge clk);
		end
		if (c >= lim) begin
			compare(32'h1, 32'h0);
			tally_and_finish();
		end
	endtask
	task automatic run_seq(input logic tm, input logic [5:0] r, input logic [4:0] c,
		input logic m);
		int ivl;
		int n;
		int other;
		int last;
		int cyc;
		int lim;
		ivl = (tm ? TSTEP : DSTEP) * (r + 1);
		ivl = m ? ivl / 8 : ivl;
		lim = ivl * (c + 3) + 50;
		n = 0;
		other = 0;
		last = 0;
		wr(10'h0fc, tm ? {16'h0, 9'h0, r, m} : {16'h0, r[3:0], c, 6'h0, m});
		wr(10'h100, {16'h0, c, 11'h0});
		wr(10'h140, {29'h0, tm, !tm, pol});
		for (cyc = 0; cyc < lim; cyc++) begin
			@(negedge clk);
			if ((tm ? temp_cmd : diff_cmd) === 1'b1) begin
				if (n > 0) begin
					compare(32'(cyc - last), 32'(ivl));
				end
				last = cyc;
				n++;
			end
			other += ((tm ? diff_cmd : temp_cmd) === 1'b1);
			if (n > 0 && busy === 1'b0) begin
				break;
			end
		end
		if (cyc >= lim) begin
			compare(32'h1, 32'h0);
			tally_and_finish();
		end else begin
			compare(32'(n), 32'(c + 1));
			compare(32'(other), 32'h0);
			$display("sequence test done tm=%0d r=%0d c=%0d m=%0d", tm, r, c, m);
		end
	endtask
	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		logic [9:0] a;
		logic [31:0] w;
		int n;
		rst = 1'b1;
		up = 1'b0;
		edge_s = 1'b0;
		pol = 1'b0;
		void'($urandom(32'hbb7c47dd));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			a = 10'h0f4 + 10'(4 * k);
			w = $urandom;
			rd(a, 32'h0);
			wr(a, w);
			rd(a, {16'h0, w[15:0] & (k < 2 ? 16'hff7f : 16'hffff)});
		end
		wr(10'h3fc, w);
		rd(10'h3fc, 32'h0);
		$display("register test done");
		pol = 1'($urandom);
		ur = {8'h80, 8'($urandom)};
		dr = {8'h7f, 8'($urandom)};
		wr(10'h0f4, {16'h0, ur});
		wr(10'h0f8, {16'h0, dr});
		wr(10'h140, {31'h0, pol});
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			up <= k[0];
			repeat (2) @(posedge clk);
			@(negedge clk);
			compare(32'(offs), exp_off(k[0], 1'b0));
		end
		wr(10'h0fc, {16'h0, 4'hf, 5'h05, 7'h00});
		wr(10'h140, {29'h0, 2'b01, pol});
		wait_cmd(20);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			up <= k[0];
			edge_s <= 1'b1;
			@(posedge clk);
			edge_s <= 1'b0;
			@(negedge clk);
			compare(32'(offs), exp_off(k[0], 1'b1));
		end
		rd(10'h144, 32'h3);
		wr(10'h140, {28'h0, 1'b1, 2'b00, pol});
		n = 0;
		repeat (700) begin
			@(negedge clk);
			n += (diff_cmd === 1'b1);
		end
		compare(32'(n), 32'h0);
		compare({31'h0, busy}, 32'h0);
		compare(32'(offs), exp_off(1'b1, 1'b0));
		rd(10'h144, 32'h0);
		rd(10'h140, {31'h0, pol});
		$display("offset test done");
		run_seq(1'b0, 6'h00, 5'h00, 1'b1);
		run_seq(1'b1, 6'h00, 5'h1f, 1'b1);
		for (int k = 0; k < 4; k++) begin
			run_seq(1'b0, 6'($urandom % 16), 5'($urandom % 8), 1'($urandom));
			run_seq(1'b1, 6'($urandom % 4), 5'($urandom % 4), 1'($urandom));
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
